// ---- core/fpic_pkg.sv ----
package fpic_pkg;
	// Register addresses on the control bus
	localparam logic [8:0] FPIC_ADDR_PATH_A = 9'h000;
	localparam logic [8:0] FPIC_ADDR_PATH_B = 9'h002;
	localparam logic [15:0] FPIC_CTRL_RESET = 16'h0000;
	// Field positions in a path control word
	localparam int FPIC_ACC_LSB = 0;
	localparam int FPIC_UNS_BIT = 2;
	localparam int FPIC_COEF_LSB = 3;
	localparam int FPIC_RATE_LSB = 8;
	localparam int FPIC_NEG_LSB = 10;
	localparam int FPIC_SRC_BIT = 13;
	localparam int FPIC_DEL_LSB = 14;
	// Field encodings
	localparam logic [1:0] FPIC_RATE_QUARTER = 2'h2;
	localparam logic [1:0] FPIC_RATE_HALF = 2'h3;
	localparam logic [2:0] FPIC_NEG_ALWAYS = 3'h4;
	localparam logic [1:0] FPIC_DEL_NONE = 2'h0;
	localparam logic [1:0] FPIC_DEL_ONE = 2'h1;
	localparam logic [1:0] FPIC_DEL_THREE = 2'h2;
	localparam logic [1:0] FPIC_DEL_COUNTER = 2'h3;
	localparam logic [4:0] FPIC_COEF_REG1 = 5'h1b;
	localparam logic [4:0] FPIC_COEF_REG3 = 5'h1f;
	localparam logic [4:0] FPIC_COEF_ALT01 = 5'h11;
	localparam logic [4:0] FPIC_COEF_ALT23 = 5'h15;
	localparam logic [4:0] FPIC_COEF_CYCLE = 5'h00;
	// Terminal count timing
	localparam int FPIC_TC_FIRST = 8;
	localparam int FPIC_TC_MULT = 16;
	localparam int FPIC_CNT_W = 16;
	localparam int FPIC_TCW = 21;
	typedef enum logic [0:0] {
		FPIC_TC_WAIT = 1'b0,
		FPIC_TC_RUN = 1'b1
	} fpic_tc_e;
endpackage : fpic_pkg

// ---- core/fpic_tc_gen.sv ----
`timescale 1ns/10ps
// Terminal-count strobe generator restarted by sync
module fpic_tc_gen import fpic_pkg::*; (
	input wire logic clk, // Clock
	input wire logic rstn, // Async reset
	input wire logic sync_ev, // Sync event, one cycle
	input wire logic [FPIC_CNT_W-1:0] cnt_val, // Counter period value
	output logic tc_ff // Strobe, one cycle
);
	fpic_tc_e state_ff;
	logic [FPIC_TCW-1:0] count_ff;
	logic [FPIC_TCW-1:0] period;

	assign period = FPIC_TCW'(FPIC_TC_MULT) * (FPIC_TCW'(cnt_val) + 1'b1);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_ff <= FPIC_TC_WAIT;
			count_ff <= '0;
			tc_ff <= 1'b0;
		end else if (sync_ev) begin
			state_ff <= FPIC_TC_RUN;
			count_ff <= FPIC_TCW'(FPIC_TC_FIRST - 1);
			tc_ff <= 1'b0;
		end else begin
			case (state_ff)
				FPIC_TC_WAIT: begin
					tc_ff <= 1'b0;
				end
				FPIC_TC_RUN: begin
					if (count_ff == FPIC_TCW'(1)) begin
						tc_ff <= 1'b1;
						count_ff <= period;
					end else begin
						tc_ff <= 1'b0;
						count_ff <= count_ff - 1'b1;
					end
				end
				default: begin
					state_ff <= FPIC_TC_WAIT;
					tc_ff <= 1'b0;
				end
			endcase
		end
	end

	tc_spacing_a: assert property (@(posedge clk) disable iff (!rstn)
		$rose(tc_ff) |=> !tc_ff)
		else $error("terminal count strobe longer than one cycle");
endmodule : fpic_tc_gen

// ---- core/fpic_path.sv ----
`timescale 1ns/10ps
// One filter path input stage
module fpic_path import fpic_pkg::*; (
	input wire logic clk, // Clock
	input wire logic rstn, // Async reset
	input wire logic sync_ev, // Sync event
	input wire logic [15:0] ctrl, // Path control word
	input wire logic [11:0] a_in, // A samples
	input wire logic [11:0] b_in, // B samples
	input wire logic [11:0] cnt_in, // Counter value as input
	output logic [11:0] samp_ff, // Captured sample
	output logic samp_vld_ff, // Capture strobe
	output logic [1:0] coef_idx_ff, // Coefficient register in use
	output logic out_vld_ff, // Accumulator output strobe
	output logic unsigned_ff // Adder unsigned mode
);
	logic [1:0] acc_sel;
	logic [4:0] coefficient_use_select;
	logic [1:0] rate_sel;
	logic [2:0] neg_sel;
	logic [1:0] input_delay_select_alt;
	logic [11:0] src;
	logic [11:0] d1_ff;
	logic [11:0] d2_ff;
	logic [11:0] d3_ff;
	logic [11:0] dly;
	logic [1:0] ph_ff;
	logic [1:0] samp_ph_ff;
	logic [1:0] acc_ff;
	logic cap;
	logic neg;
	logic [1:0] acc_last;

	assign acc_sel = ctrl[FPIC_ACC_LSB+:2];
	assign coefficient_use_select = ctrl[FPIC_COEF_LSB+:5];
	assign rate_sel = ctrl[FPIC_RATE_LSB+:2];
	assign neg_sel = ctrl[FPIC_NEG_LSB+:3];
	assign input_delay_select_alt = ctrl[FPIC_DEL_LSB+:2];
	assign src = ctrl[FPIC_SRC_BIT] ? a_in : b_in;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			d1_ff <= '0;
			d2_ff <= '0;
			d3_ff <= '0;
		end else begin
			d1_ff <= src;
			d2_ff <= d1_ff;
			d3_ff <= d2_ff;
		end
	end

	// Delays in clocks, ahead of rate capture
	always_comb begin
		case (input_delay_select_alt)
			FPIC_DEL_NONE: dly = src;
			FPIC_DEL_ONE: dly = d1_ff;
			FPIC_DEL_THREE: dly = d3_ff;
			FPIC_DEL_COUNTER: dly = cnt_in;
			default: dly = src;
		endcase
	end

	// Clock phase from sync
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) ph_ff <= '0;
		else if (sync_ev) ph_ff <= '0;
		else ph_ff <= ph_ff + 1'b1;
	end

	always_comb begin
		case (rate_sel)
			FPIC_RATE_QUARTER: cap = (ph_ff == 2'd3);
			FPIC_RATE_HALF: cap = ph_ff[0];
			default: cap = 1'b1;
		endcase
	end

	// Even/odd time of the sample being captured
	always_comb begin
		case (neg_sel)
			3'h0: neg = 1'b0;
			3'h1: neg = ~ph_ff[0];
			3'h2: neg = ph_ff[1];
			3'h3: neg = ~ph_ff[1];
			FPIC_NEG_ALWAYS: neg = 1'b1;
			3'h5: neg = ph_ff[0];
			3'h6: neg = ~ph_ff[1];
			3'h7: neg = ph_ff[1];
			default: neg = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			samp_ff <= '0;
			samp_vld_ff <= 1'b0;
			samp_ph_ff <= '0;
		end else begin
			samp_vld_ff <= cap;
			if (cap) begin
				samp_ff <= neg ? 12'(-dly) : dly;
				samp_ph_ff <= samp_ph_ff + 1'b1;
			end
			if (sync_ev) samp_ph_ff <= '0;
		end
	end

	// Coefficient selection sequence
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) coef_idx_ff <= '0;
		else begin
			case (coefficient_use_select)
				FPIC_COEF_REG1: coef_idx_ff <= 2'd1;
				FPIC_COEF_REG3: coef_idx_ff <= 2'd3;
				FPIC_COEF_ALT01: coef_idx_ff <= {1'b0, samp_ph_ff[0]};
				FPIC_COEF_ALT23: coef_idx_ff <= {1'b1, samp_ph_ff[0]};
				FPIC_COEF_CYCLE: coef_idx_ff <= samp_ph_ff;
				default: coef_idx_ff <= '0;
			endcase
		end
	end

	always_comb begin
		case (acc_sel)
			2'h2: acc_last = 2'd3;
			2'h3: acc_last = 2'd1;
			default: acc_last = 2'd0;
		endcase
	end

	// Accumulate sums and set output rate
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			acc_ff <= '0;
			out_vld_ff <= 1'b0;
		end else if (sync_ev) begin
			acc_ff <= '0;
			out_vld_ff <= 1'b0;
		end else if (samp_vld_ff) begin
			out_vld_ff <= (acc_ff >= acc_last);
			acc_ff <= (acc_ff >= acc_last) ? 2'd0 : acc_ff + 1'b1;
		end else out_vld_ff <= 1'b0;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) unsigned_ff <= 1'b0;
		else unsigned_ff <= ctrl[FPIC_UNS_BIT];
	end

	full_rate_a: assert property (@(posedge clk) disable iff (!rstn)
		(rate_sel < 2'd2) |=> samp_vld_ff)
		else $error("full rate did not capture every clock");
	neg_all_a: assert property (@(posedge clk) disable iff (!rstn)
		(neg_sel == FPIC_NEG_ALWAYS && cap) |=>
		samp_ff == 12'(-$past(dly)))
		else $error("sample not negated");
	src_sel_a: assert property (@(posedge clk) disable iff (!rstn)
		(input_delay_select_alt == FPIC_DEL_NONE && neg_sel == 3'h0 && cap
		&& ctrl[FPIC_SRC_BIT]) |=> samp_ff == $past(a_in))
		else $error("wrong input source");
	del_one_a: assert property (@(posedge clk) disable iff (!rstn)
		(input_delay_select_alt == FPIC_DEL_ONE) |-> dly == $past(src))
		else $error("one clock delay wrong");
	del_three_a: assert property (@(posedge clk) disable iff (!rstn)
		(input_delay_select_alt == FPIC_DEL_THREE) |-> dly == $past(src, 3))
		else $error("three clock delay wrong");
	uns_mode_a: assert property (@(posedge clk) disable iff (!rstn)
		1'b1 |=> unsigned_ff == $past(ctrl[FPIC_UNS_BIT]))
		else $error("unsigned mode not following control");
	coef_fix_a: assert property (@(posedge clk) disable iff (!rstn)
		coefficient_use_select == FPIC_COEF_REG3 |=> coef_idx_ff == 2'd3)
		else $error("coefficient register 3 not used");
	full_out_a: assert property (@(posedge clk) disable iff (!rstn)
		(acc_sel < 2'd2 && samp_vld_ff && !sync_ev) |=> out_vld_ff)
		else $error("full rate output missing");
endmodule : fpic_path

// ---- core/fpic_top.sv ----
`timescale 1ns/10ps
// Functional notes
// - Accumulate field 0/1 gives no accumulation, 2 sums four, 3 sums two.
// - Each path's output rate is full, half or quarter per accumulation.
// - Control bit 2 puts the cell adder into unsigned mode.
// - Coefficient field 1B, 1F, 11, 15, 00 pick reg1, reg3, 0/1, 2/3, all.
// - Rate field 0/1 is full rate, 2 quarter rate, 3 half rate input.
// - Negation field 0 leaves samples alone and 4 negates all of them.
// - Negation 1,2,3,5,6,7 negate even full, odd half, even quarter, etc.; here 3 negates no sample at quarter rate.
// - Control bit 13 takes input A when high and input B when low.
// - Delay field picks no delay, one clock, three clocks or the counter.
// - Input delays are in clocks and come before rate capture.
// - Terminal count fires 8 clocks after sync, then every 16*(count+1).
// - Path A word sits at address 0 and path B at address 2, both R/W.
// - Counters and accumulators restart on the active-low sync input.
// - The host uses chip enable, read, write, address and data lines.
module fpic_top import fpic_pkg::*; (
	input wire logic clk, // Clock
	input wire logic rstn, // Async reset, active low
	input wire logic sync_n, // Sync input, active low
	input wire logic [11:0] a_in, // Path A samples
	input wire logic [11:0] b_in, // Path B samples
	input wire logic [FPIC_CNT_W-1:0] cnt_val, // Counter period value
	input wire logic ce_n, // Chip enable
	input wire logic re_n, // Read strobe
	input wire logic we_n, // Write strobe
	input wire logic [8:0] addr, // Control address
	input wire logic [15:0] data_in, // Control data in
	output logic [15:0] data_out_ff, // Control data out
	output logic data_oe_ff, // Control data drive enable
	output logic tc_n_ff, // Terminal count strobe, active low
	output logic [11:0] a_samp_ff, // Path A captured sample
	output logic a_vld_ff, // Path A capture strobe
	output logic [1:0] a_coef_ff, // Path A coefficient index
	output logic a_out_vld_ff, // Path A output strobe
	output logic a_uns_ff, // Path A unsigned mode
	output logic [11:0] b_samp_ff, // Path B captured sample
	output logic b_vld_ff, // Path B capture strobe
	output logic [1:0] b_coef_ff, // Path B coefficient index
	output logic b_out_vld_ff, // Path B output strobe
	output logic b_uns_ff // Path B unsigned mode
);
	logic [15:0] path_a_input_control_ff;
	logic [15:0] path_b_input_control_ff;
	logic sync_d_ff;
	logic sync_ev;
	logic tc;
	logic [FPIC_CNT_W-1:0] run_cnt_ff;
	logic wr_ff;
	logic wr_go;

	// Sync event: falling edge of sync input
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) sync_d_ff <= 1'b1;
		else sync_d_ff <= sync_n;
	end
	assign sync_ev = !sync_n && sync_d_ff;

	// Write on strobe leading edge
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) wr_ff <= 1'b0;
		else wr_ff <= !ce_n && !we_n;
	end
	assign wr_go = !ce_n && !we_n && !wr_ff;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			path_a_input_control_ff <= FPIC_CTRL_RESET;
			path_b_input_control_ff <= FPIC_CTRL_RESET;
		end else if (wr_go) begin
			if (addr == FPIC_ADDR_PATH_A)
				path_a_input_control_ff <= data_in;
			if (addr == FPIC_ADDR_PATH_B)
				path_b_input_control_ff <= data_in;
		end
	end

	// Read back; drive only while read is active
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			data_out_ff <= '0;
			data_oe_ff <= 1'b0;
		end else begin
			data_oe_ff <= !ce_n && !re_n && we_n;
			case (addr)
				FPIC_ADDR_PATH_A: data_out_ff <= path_a_input_control_ff;
				FPIC_ADDR_PATH_B: data_out_ff <= path_b_input_control_ff;
				default: data_out_ff <= '0;
			endcase
		end
	end

	// Counter cleared by sync and by terminal count, offered as a path input
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) run_cnt_ff <= '0;
		else if (sync_ev || tc) run_cnt_ff <= '0;
		else run_cnt_ff <= run_cnt_ff + 1'b1;
	end

	fpic_tc_gen u_tc (
		.clk(clk),
		.rstn(rstn),
		.sync_ev(sync_ev),
		.cnt_val(cnt_val),
		.tc_ff(tc)
	);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) tc_n_ff <= 1'b1;
		else tc_n_ff <= !tc;
	end

	fpic_path u_path_a (
		.clk(clk),
		.rstn(rstn),
		.sync_ev(sync_ev),
		.ctrl(path_a_input_control_ff),
		.a_in(a_in),
		.b_in(b_in),
		.cnt_in(run_cnt_ff[11:0]),
		.samp_ff(a_samp_ff),
		.samp_vld_ff(a_vld_ff),
		.coef_idx_ff(a_coef_ff),
		.out_vld_ff(a_out_vld_ff),
		.unsigned_ff(a_uns_ff)
	);

	fpic_path u_path_b (
		.clk(clk),
		.rstn(rstn),
		.sync_ev(sync_ev),
		.ctrl(path_b_input_control_ff),
		.a_in(a_in),
		.b_in(b_in),
		.cnt_in(run_cnt_ff[11:0]),
		.samp_ff(b_samp_ff),
		.samp_vld_ff(b_vld_ff),
		.coef_idx_ff(b_coef_ff),
		.out_vld_ff(b_out_vld_ff),
		.unsigned_ff(b_uns_ff)
	);

	reg_write_a: assert property (@(posedge clk) disable iff (!rstn)
		(wr_go && addr == FPIC_ADDR_PATH_B) |=>
		path_b_input_control_ff == $past(data_in))
		else $error("path B control write lost");
	read_drive_a: assert property (@(posedge clk) disable iff (!rstn)
		(ce_n || re_n) |=> !data_oe_ff)
		else $error("data bus driven without read");
	tc_first_a: assert property (@(posedge clk) disable iff (!rstn)
		sync_ev ##1 !sync_ev [*7] |=> tc)
		else $error("terminal count not eight clocks after sync");
endmodule : fpic_top

// ---- sim/fpic_src_model.sv ----
`timescale 1ns/10ps
// Sample source on the far side of both paths
module fpic_src_model (
	output logic [11:0] a_smp, // Path A samples
	output logic [11:0] b_smp // Path B samples
);
	// Fixed levels keep captured values phase-free
	initial begin
		a_smp = 12'h123;
		b_smp = 12'h456;
	end
endmodule : fpic_src_model

// ---- sim/filter_path_input_control_test.sv ----
`timescale 1ns/10ps
module filter_path_input_control_test import fpic_pkg::*;;
	logic clk = 0, rstn = 0, sync_n = 1, ce_n = 1, re_n = 1, we_n = 1;
	logic [15:0] cnt_val = 16'h0002, data_in = 16'h0000, dout, rv;
	logic [8:0] addr = 9'h000;
	logic [11:0] a_in, b_in, a_samp, b_samp;
	logic oe, tc_n, a_vld, b_vld, a_ov, b_ov, a_uns, b_uns;
	logic [1:0] a_coef, b_coef;
	int n_fail = 0, n_checks = 0;
	always #5 clk = ~clk;
	fpic_src_model fpic_src_model_inst (.a_smp(a_in), .b_smp(b_in));
	fpic_top fpic_top_inst (.clk(clk), .rstn(rstn), .sync_n(sync_n),
		.a_in(a_in), .b_in(b_in), .cnt_val(cnt_val), .ce_n(ce_n),
		.re_n(re_n), .we_n(we_n), .addr(addr), .data_in(data_in),
		.data_out_ff(dout), .data_oe_ff(oe), .tc_n_ff(tc_n),
		.a_samp_ff(a_samp), .a_vld_ff(a_vld), .a_coef_ff(a_coef),
		.a_out_vld_ff(a_ov), .a_uns_ff(a_uns), .b_samp_ff(b_samp),
		.b_vld_ff(b_vld), .b_coef_ff(b_coef), .b_out_vld_ff(b_ov),
		.b_uns_ff(b_uns));
	task chk(input string what, input logic [15:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s exp %h seen %h", what, exp, seen);
		end
	endtask : chk
	task wrap_up;
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : wrap_up
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task wr(input logic [8:0] a, input logic [15:0] d);
		ce_n = 0;
		we_n = 0;
		addr = a;
		data_in = d;
		tick(1);
		ce_n = 1;
		we_n = 1;
		tick(1);
	endtask : wr
	task rd(input logic [8:0] a, output logic [15:0] d);
		ce_n = 0;
		re_n = 0;
		addr = a;
		tick(2);
		chk("data_oe", {15'h0000, oe}, 16'h0001);
		d = dout;
		ce_n = 1;
		re_n = 1;
		tick(1);
	endtask : rd
	task t_regs;
		rd(9'h000, rv);
		chk("reset a", rv, FPIC_CTRL_RESET);
		rd(9'h002, rv);
		chk("reset b", rv, FPIC_CTRL_RESET);
		wr(9'h000, 16'ha5c3);
		wr(9'h002, 16'h5a3c);
		wr(9'h004, 16'hffff);
		rd(9'h000, rv);
		chk("word a", rv, 16'ha5c3);
		rd(9'h002, rv);
		chk("word b", rv, 16'h5a3c);
		rd(9'h004, rv);
		chk("unmapped", rv, 16'h0000);
	endtask : t_regs
	task t_tc;
		int n;
		n = 0;
		sync_n = 0;
		do begin
			tick(1);
			sync_n = 1;
			n++;
		end while (tc_n !== 1'b0 && n < 100);
		chk("tc first", n[15:0], 16'(FPIC_TC_FIRST + 1));
		n = 0;
		do begin
			tick(1);
			n++;
		end while (tc_n !== 1'b0 && n < 100);
		chk("tc period", n[15:0], 16'(16 * (2 + 1)));
	endtask : t_tc
	task t_src;
		wr(9'h000, 16'h0004);
		wr(9'h002, 16'h3000);
		tick(6);
		chk("a from b", {4'h0, a_samp}, 16'h0456);
		chk("b neg a", {4'h0, b_samp}, 16'h0edd);
		chk("a uns", {15'h0000, a_uns}, 16'h0001);
		chk("b uns", {15'h0000, b_uns}, 16'h0000);
	endtask : t_src
	task t_coef;
		logic [4:0] codes [5] = '{5'h1b, 5'h1f, 5'h11, 5'h15, 5'h00};
		logic [3:0] masks [5] = '{4'h2, 4'h8, 4'h3, 4'hc, 4'hf};
		logic [3:0] m;
		for (int i = 0; i < 5; i++) begin
			wr(9'h000, {8'h00, codes[i], 3'h0});
			tick(4);
			m = 4'h0;
			repeat (8) begin
				m = m | (4'h1 << a_coef);
				tick(1);
			end
			chk("coef set", {12'h000, m}, {12'h000, masks[i]});
		end
	endtask : t_coef
	task t_rate;
		int nv, no, ex;
		for (int r = 0; r < 4; r++) begin
			ex = (r < 2) ? 32 : ((r == 2) ? 8 : 16);
			// Input rate alone, then accumulation at full input rate
			wr(9'h000, {6'h00, 2'(r), 8'h00});
			tick(4);
			nv = 0;
			repeat (32) begin
				nv += int'(a_vld === 1'b1);
				tick(1);
			end
			wr(9'h000, {14'h0000, 2'(r)});
			tick(4);
			no = 0;
			repeat (32) begin
				no += int'(a_ov === 1'b1);
				tick(1);
			end
			chk("in rate", nv[15:0], ex[15:0]);
			chk("out rate", no[15:0], ex[15:0]);
		end
	endtask : t_rate
	task t_neg;
		logic [2:0] codes [4] = '{3'h1, 3'h5, 3'h2, 3'h6};
		logic [1:0] rates [4] = '{2'h0, 2'h0, 2'h3, 2'h3};
		int n;
		for (int i = 0; i < 4; i++) begin
			wr(9'h000, {3'h1, codes[i], rates[i], 8'h00});
			tick(6);
			n = 0;
			repeat (32) begin
				n += int'(a_samp === 12'hedd);
				tick(1);
			end
			chk("neg share", n[15:0], 16'h0010);
		end
	endtask : t_neg
	initial begin
		tick(10);
		rstn = 1;
		tick(1);
		t_regs;
		t_tc;
		t_src;
		t_coef;
		t_rate;
		t_neg;
		wrap_up;
	end
endmodule : filter_path_input_control_test
